// file: hdl/vme_err_pkg.sv
// Constants for the VMEbus error and status logger.
// Assumes a single 10 MHz system clock and an Avalon-MM register port.
package vme_err_pkg;
  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CONFIG = 8'h40;
  localparam logic [7:0] OFS_ERROR_SUMMARY = 8'h44;
  localparam logic [7:0] OFS_FAILING_ADDRESS = 8'h48;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h4C;
  // ==========================================================================
  // Error summary field positions
  localparam int B_SWAP_PAR = 31;
  localparam int B_BERR = 30;
  localparam int B_INTERLOCK = 29;
  localparam int B_RMW_II = 28;
  localparam int B_RMW_I = 27;
  localparam int B_VME_TX_PAR = 26;
  localparam int B_LINK_TX_PAR = 25;
  localparam int B_LINK_RX_PAR = 24;
  localparam int B_XACT_TMO = 23;
  localparam int B_ARB_TMO = 22;
  localparam int B_GRANT_LO = 20;
  localparam int B_AM_LO = 14;
  localparam int B_DS1 = 13;
  localparam int B_DS0 = 12;
  localparam int B_SYSRESET = 11;
  localparam int B_IRQ_LO = 4;
  localparam int B_SENT_LO = 0;
  // Configuration register fields
  localparam int B_CFG_SUMMARY = 28;
  localparam int B_CFG_REV_LO = 8;
  // Flags that count toward the configuration error summary bit
  localparam logic [31:0] SUMMARY_MASK = 32'h7FC0_0000;
  // Write-one-to-clear flag bits of the error summary register
  localparam logic [31:0] W1C_MASK = 32'hBFC0_0800;
  // ==========================================================================
  // Reset values
  localparam logic [5:0] AM_RESET = 6'h3F;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage : vme_err_pkg

// file: hdl/vme_error_status_logger.sv
// VMEbus error and status logger: error summary, failing address and
// configuration identity registers, reached over Avalon-MM.
// Assumes VMEbus and internal-link event pulses come from same-clock logic;
// the raw VMEbus lines (BERR*, SYSRESET*, IRQn*, AMs, DSs) arrive async.
`timescale 1ns/1ps
module vme_error_status_logger
  import vme_err_pkg::*;
#(
  parameter logic [7:0] DEVICE_TYPE = 8'h5A, // Arbitrary identity value
  parameter int NUM_IRQ = 7,
  parameter int NUM_SENT = 4
) (
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // Straps
  input wire logic [3:0] module_revision_field_i,
  // Asynchronous VMEbus lines (active low where marked)
  input wire logic berr_n_i,
  input wire logic sysreset_n_i,
  input wire logic [NUM_IRQ-1:0] irq_n_i,
  input wire logic [5:0] am_i,
  input wire logic ds1_n_i,
  input wire logic ds0_n_i,
  input wire logic [31:1] vme_addr_i,
  // Same-clock event inputs
  input wire logic swap_par_err_i,
  input wire logic interlock_start_i,
  input wire logic link_xact_i,
  input wire logic link_unlock_i,
  input wire logic plain_read_rmw_window_i,
  input wire logic plain_read_done_i,
  input wire logic rmw_write_plain_window_i,
  input wire logic vme_tx_par_err_i,
  input wire logic link_tx_par_err_i,
  input wire logic link_rx_par_err_i,
  input wire logic xact_timeout_i,
  input wire logic is_master_i,
  input wire logic arb_timeout_i,
  input wire logic arb_cycle_i,
  input wire logic [1:0] grant_level_i,
  input wire logic [NUM_IRQ-1:0] iack_i,
  input wire logic [NUM_IRQ-1:0] ack_released_interrupter_i,
  input wire logic [NUM_SENT-1:0] irq_sent_i,
  input wire logic [NUM_SENT-1:0] ident_i,
  // Actions toward the VMEbus and link
  output logic berr_drive_o,
  output logic release_bus_o,
  output logic unlock_write_o,
  output logic abort_o,
  output logic rearbitrate_o,
  output logic err_event_o,
  output logic unmaskable_event_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [2:0] berr_s;
    logic [2:0] sysrst_s;
    logic [NUM_IRQ-1:0] irq_s0;
    logic [NUM_IRQ-1:0] irq_s1;
    logic [NUM_IRQ-1:0] irq_s2;
    logic [5:0] am_s0;
    logic [5:0] am_s1;
    logic [1:0] ds_s0;
    logic [1:0] ds_s1;
    logic [5:0] am_s2;
    logic [1:0] ds_s2;
    logic berr_lvl;
    logic wait_req;
    logic [31:0] esr;
    logic [31:1] fail_addr;
    logic [3:0] rev;
    logic berr_force;
    logic lock_wait;
    logic rmw2_wait;
    logic [31:0] rdata;
    logic wait_n;
    logic [1:0] resp;
    logic berr_drive;
    logic release_bus;
    logic unlock_write;
    logic abort;
    logic rearb;
    logic err_ev;
    logic unm_ev;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  // ==========================================================================
  // How the logger works
  //
  // All state lives in one packed struct. The combinational process below
  // starts from the registered copy and overrides only what changes this
  // cycle, so every field keeps its value unless some branch says otherwise.
  // The clock enable gates the single register stage, which freezes the
  // synchronisers, the flags, the snapshots and the bus answer together.
  //
  // Asynchronous VMEbus lines pass three flip-flops. A change is accepted
  // only once the second and third stages agree; a single glitch that lands
  // in the first stage never reaches the flags. The price is three cycles of
  // latency, which at 10 MHz is small next to any VMEbus cycle.
  //
  // Error flags are sticky and cleared by writing one. A set that falls in
  // the same cycle as the clearing write wins, so an event is never lost to
  // a software clear that raced it. Software must read, then clear only the
  // bits it has handled.
  //
  // The bus error bit is not sticky: it mirrors the synchronised line, ORed
  // with our own drive. Writing one to it latches a force bit for
  // diagnostics; writing zero releases the force.
  //
  // Interlock checking is a one-deep wait: after the start pulse the next
  // link transaction must be the unlock. Any other transaction raises the
  // error and a release pulse, but is still executed by the transaction
  // engine outside this block; nothing here blocks or drops traffic.
  //
  // The plain-read-to-interlocked-window path waits for the read data to go
  // back before it asks for the zero unlock write, so the VME master is not
  // held up by the cleanup.
  //
  // The snapshot fields (grant level, address modifiers, data strobes)
  // follow the bus while no timeout flag is set. Either timeout flag locks
  // them, and they stay locked until software clears that flag. The cycle
  // that carries the timeout pulse itself is already excluded, so the
  // snapshot shows the bus as it stood when the timer fired.
  //
  // Interrupt pending bits for acknowledge-released levels clear on the
  // acknowledge strobe of their level. A level that is still seen asserted
  // through the synchroniser sets its bit again, which is why the strobe
  // must outlast the synchroniser delay when the line is released late.
  // Register-released levels are cleared by software writing one.
  //
  // The register port answers every request after one wait cycle. The
  // waitrequest output is a flip-flop that idles high and drops for exactly
  // the answer cycle. Unmapped addresses answer with a slave error and zero
  // data, and writes to them change nothing.
  //
  // Outputs toward the VMEbus side are one-cycle pulses, registered one
  // cycle after their cause, except the bus error drive, which is a level
  // while the force bit is set.
  //
  // Limitation: the failing address is latched only when the device was
  // bus master at the timeout pulse; otherwise it keeps its old contents.
  // ==========================================================================

  // Decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic req;
  logic wr_esr;
  logic [31:0] w1c;
  logic berr_low;
  logic sysrst_rise;
  logic lock_tmo;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    req = (avs_read_i | avs_write_i) & ~st_ff.wait_n;
    wr_esr = req & avs_write_i & hit(avs_address_i, OFS_ERROR_SUMMARY) & (&avs_byteenable_i);
    w1c = wr_esr ? (avs_writedata_i & W1C_MASK) : DATA_ZERO;
    // Sync stages; only agreeing 2nd/3rd stages are used
    nxt_st.berr_s = {st_ff.berr_s[1:0], ~berr_n_i};
    nxt_st.sysrst_s = {st_ff.sysrst_s[1:0], ~sysreset_n_i};
    nxt_st.irq_s0 = ~irq_n_i;
    nxt_st.irq_s1 = st_ff.irq_s0;
    nxt_st.irq_s2 = st_ff.irq_s1;
    nxt_st.am_s0 = am_i;
    nxt_st.am_s1 = st_ff.am_s0;
    nxt_st.ds_s0 = {~ds1_n_i, ~ds0_n_i};
    nxt_st.ds_s1 = st_ff.ds_s0;
    nxt_st.am_s2 = st_ff.am_s1;
    nxt_st.ds_s2 = st_ff.ds_s1;
    // Bus error level changes only when the later stages agree
    if (st_ff.berr_s[1] == st_ff.berr_s[2]) begin
      nxt_st.berr_lvl = st_ff.berr_s[2];
    end
    berr_low = st_ff.berr_lvl;
    sysrst_rise = st_ff.sysrst_s[1] & st_ff.sysrst_s[2] & ~st_ff.esr[B_SYSRESET];
    lock_tmo = st_ff.esr[B_XACT_TMO] | st_ff.esr[B_ARB_TMO];
    // Clear on write one; a simultaneous set below wins
    nxt_st.esr = st_ff.esr & ~w1c;
    if (wr_esr) begin
      nxt_st.berr_force = avs_writedata_i[B_BERR];
    end
    nxt_st.rev = module_revision_field_i;
    nxt_st.err_ev = 1'b0;
    nxt_st.unm_ev = 1'b0;
    nxt_st.release_bus = 1'b0;
    nxt_st.unlock_write = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.rearb = 1'b0;
    // Set on every swap parity error, each one raising the event; sticky until cleared
    if (swap_par_err_i) begin
      nxt_st.esr[B_SWAP_PAR] = 1'b1;
      nxt_st.err_ev = 1'b1;
    end
    // Live bus error line, plus our own drive from the bus timer or the force bit
    nxt_st.esr[B_BERR] = berr_low | st_ff.berr_drive;
    // Interlock pairing: the next link transaction must be the unlock
    if (interlock_start_i) begin
      nxt_st.lock_wait = 1'b1;
    end else if (st_ff.lock_wait && link_xact_i) begin
      nxt_st.lock_wait = 1'b0;
      if (!link_unlock_i) begin
        nxt_st.esr[B_INTERLOCK] = 1'b1;
        nxt_st.release_bus = 1'b1;
        nxt_st.err_ev = 1'b1;
      end
    end
    // Transactions are never blocked here; the executor keeps running them
    // Plain read to interlocked window: unlock after data returned
    if (plain_read_rmw_window_i) begin
      nxt_st.rmw2_wait = 1'b1;
    end else if (st_ff.rmw2_wait && plain_read_done_i) begin
      nxt_st.rmw2_wait = 1'b0;
      nxt_st.unlock_write = 1'b1;
      nxt_st.esr[B_RMW_II] = 1'b1;
      nxt_st.err_ev = 1'b1;
    end
    if (rmw_write_plain_window_i) begin
      nxt_st.esr[B_RMW_I] = 1'b1;
      nxt_st.err_ev = 1'b1;
    end
    if (vme_tx_par_err_i) begin
      nxt_st.esr[B_VME_TX_PAR] = 1'b1;
      nxt_st.abort = 1'b1;
      nxt_st.err_ev = 1'b1;
    end
    if (link_tx_par_err_i) begin
      nxt_st.esr[B_LINK_TX_PAR] = 1'b1;
      nxt_st.unm_ev = 1'b1;
    end
    if (link_rx_par_err_i) begin
      nxt_st.esr[B_LINK_RX_PAR] = 1'b1;
      nxt_st.abort = 1'b1;
      nxt_st.err_ev = 1'b1;
    end
    // Timer drives BERR* for one cycle to clear the stalled cycle
    nxt_st.berr_drive = xact_timeout_i | nxt_st.berr_force;
    if (xact_timeout_i) begin
      nxt_st.esr[B_XACT_TMO] = 1'b1;
      nxt_st.err_ev = 1'b1;
      if (is_master_i) begin
        nxt_st.fail_addr = vme_addr_i;
      end
    end
    if (arb_timeout_i) begin
      nxt_st.esr[B_ARB_TMO] = 1'b1;
      nxt_st.rearb = 1'b1;
      nxt_st.err_ev = 1'b1;
    end
    // Snapshots follow the bus until a timeout flag locks them
    if (!lock_tmo && !xact_timeout_i && !arb_timeout_i) begin
      if (arb_cycle_i) begin
        nxt_st.esr[B_GRANT_LO+1:B_GRANT_LO] = grant_level_i;
      end
      if (st_ff.am_s1 == st_ff.am_s2) begin
        nxt_st.esr[B_AM_LO+5:B_AM_LO] = st_ff.am_s2;
      end
      if (st_ff.ds_s1 == st_ff.ds_s2) begin
        nxt_st.esr[B_DS1] = st_ff.ds_s2[1];
        nxt_st.esr[B_DS0] = st_ff.ds_s2[0];
      end
    end
    if (sysrst_rise) begin
      nxt_st.esr[B_SYSRESET] = 1'b1;
      nxt_st.unm_ev = 1'b1;
    end
    // Pending levels: set on asserted request, clear on IACK or software
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (st_ff.irq_s1[i] && st_ff.irq_s2[i]) begin
        nxt_st.esr[B_IRQ_LO+i] = 1'b1;
      end else if (iack_i[i] && ack_released_interrupter_i[i]) begin
        nxt_st.esr[B_IRQ_LO+i] = 1'b0;
      end else if (w1c[B_IRQ_LO+i] || (wr_esr && avs_writedata_i[B_IRQ_LO+i]
                   && !ack_released_interrupter_i[i])) begin
        nxt_st.esr[B_IRQ_LO+i] = 1'b0;
      end
    end
    for (int j = 0; j < NUM_SENT; j++) begin
      if (irq_sent_i[j]) begin
        nxt_st.esr[B_SENT_LO+j] = 1'b1;
      end else if (ident_i[j]) begin
        nxt_st.esr[B_SENT_LO+j] = 1'b0;
      end
    end
    // Register bus: one wait cycle, then answer
    nxt_st.wait_n = req;
    nxt_st.wait_req = ~req; // Low only in the answer cycle
    nxt_st.resp = 2'h0;
    nxt_st.rdata = DATA_ZERO;
    if (req) begin
      if (hit(avs_address_i, OFS_CONFIG)) begin
        nxt_st.rdata[7:0] = DEVICE_TYPE;
        nxt_st.rdata[B_CFG_REV_LO+3:B_CFG_REV_LO] = st_ff.rev;
        nxt_st.rdata[B_CFG_SUMMARY] = |(st_ff.esr & SUMMARY_MASK);
      end else if (hit(avs_address_i, OFS_ERROR_SUMMARY)) begin
        nxt_st.rdata = st_ff.esr;
      end else if (hit(avs_address_i, OFS_FAILING_ADDRESS)) begin
        nxt_st.rdata = {st_ff.fail_addr, 1'b0};
      end else begin
        nxt_st.resp = 2'h2; // Unmapped: slave error
      end
    end
  end

  // ==========================================================================
  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.esr[B_AM_LO+5:B_AM_LO] <= AM_RESET;
      st_ff.am_s1 <= AM_RESET;
      st_ff.am_s0 <= AM_RESET;
      st_ff.am_s2 <= AM_RESET;
      st_ff.wait_req <= 1'b1;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = st_ff.wait_req;
  assign avs_response_o = st_ff.resp;
  assign berr_drive_o = st_ff.berr_drive;
  assign release_bus_o = st_ff.release_bus;
  assign unlock_write_o = st_ff.unlock_write;
  assign abort_o = st_ff.abort;
  assign rearbitrate_o = st_ff.rearb;
  assign err_event_o = st_ff.err_ev;
  assign unmaskable_event_o = st_ff.unm_ev;

endmodule // vme_error_status_logger

// file: test/tb_top.sv
// Bench for the VMEbus error logger: registers, flags, interrupts.
// Assumes the far-side model drives the VMEbus lines.
`timescale 1ns/1ps
module tb_top;
  import vme_err_pkg::*;
  // ==========================================================
  // Stimulus and observation
  localparam logic [3:0] REV = 4'h9;
  localparam logic [31:0] CFG = 32'h0000_095A;
  logic clk_sys_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o, rdat, base;
  logic [1:0] avs_response_o, rsp;
  logic avs_waitrequest_o, release_bus_o, sysreset_n, berr_n, ds1_n, ds0_n;
  logic [31:1] vme_addr_i = 31'h0;
  logic [12:0] ev = 13'h0;
  logic [1:0] grant = 2'h2;
  logic [6:0] irq_req = 7'h0, iack = 7'h0, irq_n;
  logic [3:0] sent = 4'h0, ident = 4'h0;
  logic [5:0] am;
  logic sysres = 1'h0;
  logic rel_seen = 1'h0;
  logic unlock_write_o, err_event_o;
  logic unl_seen = 1'h0;
  logic evt_seen = 1'h0;
  int err_total = 0;
  int compares = 0;
  // Clock of 100 ns period
  always #50 clk_sys_i = ~clk_sys_i;
  // Catch the one-cycle bus release, unlock write and error event pulses
  always @(posedge clk_sys_i) if (release_bus_o === 1'h1) rel_seen <= 1'h1;
  always @(posedge clk_sys_i) if (unlock_write_o === 1'h1) unl_seen <= 1'h1;
  always @(posedge clk_sys_i) if (err_event_o === 1'h1) evt_seen <= 1'h1;
  vme_error_status_logger i_dut (
    .clk_sys_i, .rst_n_i, .clk_en_i(1'h1), .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
    .avs_response_o, .module_revision_field_i(REV), .berr_n_i(berr_n),
    .sysreset_n_i(sysreset_n), .irq_n_i(irq_n), .am_i(am), .ds1_n_i(ds1_n), .ds0_n_i(ds0_n),
    .vme_addr_i, .swap_par_err_i(ev[0]), .interlock_start_i(ev[1]), .link_xact_i(ev[2]),
    .link_unlock_i(ev[3]), .plain_read_rmw_window_i(ev[4]), .plain_read_done_i(ev[5]),
    .rmw_write_plain_window_i(ev[6]), .vme_tx_par_err_i(ev[7]), .link_tx_par_err_i(ev[8]),
    .link_rx_par_err_i(ev[9]), .xact_timeout_i(ev[10]), .is_master_i(1'h1),
    .arb_timeout_i(ev[11]), .arb_cycle_i(ev[12]), .grant_level_i(grant), .iack_i(iack),
    .ack_released_interrupter_i(7'h7F), .irq_sent_i(sent), .ident_i(ident),
    .berr_drive_o(), .release_bus_o, .unlock_write_o, .abort_o(), .rearbitrate_o(),
    .err_event_o, .unmaskable_event_o());
  vme_far_model i_far (.clk_sys_i, .rst_n_i, .irq_req_i(irq_req), .iack_i(iack),
    .sysres_i(sysres), .irq_n_o(irq_n), .sysreset_n_o(sysreset_n), .berr_n_o(berr_n),
    .am_o(am), .ds1_n_o(ds1_n), .ds0_n_o(ds0_n));
  // ==========================================================
  // Verdict, compare and bus helpers
  task automatic print_verdict();
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Hold the request until waitrequest is seen low, bounded
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= we;
    avs_read_i <= !we;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 20);
    rdat = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic pulse(input logic [12:0] m);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 13'h0;
    @(posedge clk_sys_i);
  endtask
  // Raise one flag, see it and the summary bit, clear it by writing one
  task automatic flag(input logic [12:0] m1, input logic [12:0] m2, input int b);
    logic [31:0] f;
    f = 32'h1 << b;
    pulse(m1);
    pulse(m2);
    rd(OFS_ERROR_SUMMARY, base | f);
    if (b == 23) rd(OFS_FAILING_ADDRESS, {vme_addr_i, 1'h0});
    rd(OFS_CONFIG, CFG | {3'h0, |(f & SUMMARY_MASK), 28'h0});
    bus(1'h1, OFS_ERROR_SUMMARY, f);
    rd(OFS_ERROR_SUMMARY, base);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(OFS_ERROR_SUMMARY, 32'h000F_C000);
    bus(1'h1, OFS_CONFIG, 32'hFFFF_FFFF);
    rd(OFS_CONFIG, CFG);
    rd(OFS_IRQ_ENABLE, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    pulse(13'h1000);
    base = 32'h002F_C000;
    grant <= 2'h1;
    rd(OFS_ERROR_SUMMARY, base);
  endtask
  task automatic t_flags();
    flag(13'h0001, 13'h0000, 31);
    chk({31'h0, evt_seen}, 32'h1);
    flag(13'h0002, 13'h0004, 29);
    chk({31'h0, rel_seen}, 32'h1);
    flag(13'h0010, 13'h0020, 28);
    chk({31'h0, unl_seen}, 32'h1);
    flag(13'h0040, 13'h0000, 27);
    flag(13'h0080, 13'h0000, 26);
    flag(13'h0100, 13'h0000, 25);
    flag(13'h0200, 13'h0000, 24);
    vme_addr_i <= 31'h2AB4_C3D2;
    flag(13'h0400, 13'h1000, 23);
    flag(13'h0800, 13'h0000, 22);
    pulse(13'h1000);
    rd(OFS_ERROR_SUMMARY, 32'h001F_C000);
  endtask
  task automatic t_irq();
    base = 32'h001F_C000;
    irq_req <= 7'h04;
    sent <= 4'h4;
    sysres <= 1'h1;
    @(posedge clk_sys_i);
    irq_req <= 7'h0;
    sent <= 4'h0;
    repeat (6) @(posedge clk_sys_i);
    rd(OFS_ERROR_SUMMARY, base | 32'h0844);
    iack <= 7'h04;
    ident <= 4'h4;
    sysres <= 1'h0;
    repeat (5) @(posedge clk_sys_i);
    iack <= 7'h0;
    ident <= 4'h0;
    repeat (6) @(posedge clk_sys_i);
    rd(OFS_ERROR_SUMMARY, base | 32'h0800);
    bus(1'h1, OFS_ERROR_SUMMARY, 32'h0800);
    rd(OFS_ERROR_SUMMARY, base);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    t_regs();
    t_flags();
    t_irq();
    print_verdict();
  end
endmodule // tb_top

// file: test/vme_err_monitor.sv
// Concurrent checks on the VMEbus error logger ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module vme_err_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  // Events and actions
  input wire logic sysreset_n_i,
  input wire logic vme_tx_par_err_i,
  input wire logic link_tx_par_err_i,
  input wire logic link_rx_par_err_i,
  input wire logic xact_timeout_i,
  input wire logic arb_timeout_i,
  input wire logic berr_drive_o,
  input wire logic abort_o,
  input wire logic rearbitrate_o,
  input wire logic unmaskable_event_o
);
  // ==========================================================
  // Bus handshake steps
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o;
  endsequence
  bus_answer_a: assert property (s_take |=> s_answer) else $error("late answer");
  unmapped_resp_a: assert property (s_take ##0 avs_address_i == 8'h4C |=> s_answer ##0
    avs_response_o == 2'h2) else $error("unmapped not refused");
  // ==========================================================
  // Error actions, one cycle after their cause
  tx_abort_a: assert property (vme_tx_par_err_i |=> abort_o) else $error("no abort");
  rx_abort_a: assert property (link_rx_par_err_i |=> abort_o) else $error("no abort");
  link_par_irq_a: assert property (link_tx_par_err_i |=> unmaskable_event_o)
    else $error("no event");
  tmo_berr_a: assert property (xact_timeout_i |=> berr_drive_o) else $error("no berr");
  arb_retry_a: assert property (arb_timeout_i |=> rearbitrate_o) else $error("no retry");
  // Sync chain of three flops bounds the wait
  sysreset_irq_a: assert property ($fell(sysreset_n_i) |-> ##[1:6] unmaskable_event_o)
    else $error("no sysreset event");
endmodule // vme_err_monitor

bind vme_error_status_logger vme_err_monitor i_mon (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
  .sysreset_n_i(sysreset_n_i), .vme_tx_par_err_i(vme_tx_par_err_i),
  .link_tx_par_err_i(link_tx_par_err_i), .link_rx_par_err_i(link_rx_par_err_i),
  .xact_timeout_i(xact_timeout_i), .arb_timeout_i(arb_timeout_i), .berr_drive_o(berr_drive_o),
  .abort_o(abort_o), .rearbitrate_o(rearbitrate_o), .unmaskable_event_o(unmaskable_event_o));

// file: test/vme_far_model.sv
// Behavioural VMEbus far side: interrupters, reset source, idle lines.
// Assumes bench requests arrive on the system clock.
`timescale 1ns/1ps
module vme_far_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Bench requests
  input wire logic [6:0] irq_req_i,
  input wire logic [6:0] iack_i,
  input wire logic sysres_i,
  // VMEbus lines, active low, pulled up when idle
  output logic [6:0] irq_n_o,
  output logic sysreset_n_o,
  output logic berr_n_o,
  output logic [5:0] am_o,
  output logic ds1_n_o,
  output logic ds0_n_o
);
  logic [6:0] held_ff;
  // ==========================================================
  // Ack-released interrupters drop their line only on acknowledge
  always_ff @(posedge clk_sys_i) begin
    held_ff <= rst_n_i ? (held_ff | irq_req_i) & ~iack_i : 7'h00;
  end
  // Idle lines sit at their pull-up level
  assign irq_n_o = ~held_ff;
  assign sysreset_n_o = ~sysres_i;
  assign berr_n_o = 1'h1;
  assign am_o = 6'h3F;
  assign ds1_n_o = 1'h1;
  assign ds0_n_o = 1'h1;
endmodule // vme_far_model
